// ---- core/tbq_framer.sv ----
// slot fifo and the framer with scrambler, mapper and receive alignment
`timescale 1ns/1ps

module tbq_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] rd_ptr, wr_ptr;
    logic [AW:0] count;
    logic push, pop;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("fifo depth must be a power of two, at least 2");
    end

    assign in_ready = count != (AW + 1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// Behaviour
// - sign then magnitude bit form each symbol
// - four levels, two bits per symbol
// - pair user bits, scramble B and D
// - overhead bits paired and scrambled alike
// - receiver demaps, descrambles and demultiplexes
// - symbol rate is 80 kbaud
// - free running rate within 100 ppm
// - frame is 120 symbols, 1.5 ms
// - sync 1-9, data 10-117, overhead 118-120
// - twelve 18-bit slots per frame
// - slot: two octets then D pair
// - first D bit becomes sign bit
// - normal frames start with sync word
// - multiframe start uses inverted sync word
// - same sync codes both directions
// - eight frames, start found by inversion
// - sync word places channels, optional timing
// - transmit frame 60 symbols after receive
// - alignment method free, meet time limits
// - everything but sync word is scrambled
// - 48 overhead bits per multiframe carried
module tbq_framer #(
    parameter int ALIGN_COUNT = tbq_pkg::ALIGN_DEF,
    parameter int LOSS_COUNT = tbq_pkg::LOSS_DEF,
    parameter logic [22:0] TX_TAPS = tbq_pkg::SCR_TAPS_DEF,
    parameter logic [22:0] RX_TAPS = tbq_pkg::SCR_TAPS_DEF,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic tx_slot_valid,
    output logic tx_slot_ready,
    input wire logic [17:0] tx_slot_data,
    input wire logic [5:0] tx_overhead,
    output logic [1:0] tx_symbol,
    output logic tx_symbol_valid,
    output logic [2:0] tx_frame_number,
    input wire logic [1:0] rx_symbol,
    input wire logic rx_symbol_valid,
    output logic [17:0] rx_slot_data,
    output logic rx_slot_valid,
    output logic [5:0] rx_overhead,
    output logic rx_overhead_valid,
    output logic [2:0] rx_frame_number,
    output logic rx_aligned
);
    localparam int PW = tbq_pkg::POS_W;
    localparam int CW = tbq_pkg::CNT_W;

    if (ALIGN_COUNT < 1 || ALIGN_COUNT > 15 || LOSS_COUNT < 1 || LOSS_COUNT > 15) begin : g_chk
        $error("alignment counts must lie in 1..15");
    end

    function automatic logic feedback(input logic [22:0] sr, input logic [22:0] taps);
        feedback = ^(sr & taps);
    endfunction
    function automatic logic [3:0] slot_phase(input logic [6:0] pos);
        slot_phase = 4'((pos - PW'(tbq_pkg::SYNC_SYMS)) % PW'(tbq_pkg::SLOT_SYMS));
    endfunction
    function automatic logic in_data_area(input logic [6:0] pos);
        in_data_area = pos >= PW'(tbq_pkg::SYNC_SYMS) && pos < PW'(tbq_pkg::OVH_START);
    endfunction

    // symbol rate tick from fractional accumulator, exact on average
    logic [tbq_pkg::ACC_W-1:0] acc, acc_sum;
    logic free_tick;
    assign acc_sum = acc + tbq_pkg::ACC_W'(tbq_pkg::ACC_STEP);
    assign free_tick = acc_sum >= tbq_pkg::ACC_W'(tbq_pkg::ACC_MOD);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            acc <= '0;
        end else if (free_tick) begin
            acc <= acc_sum - tbq_pkg::ACC_W'(tbq_pkg::ACC_MOD);
        end else begin
            acc <= acc_sum;
        end
    end

    logic ff_valid, ff_pop;
    logic [17:0] ff_data;

    tbq_fifo #(
        .WIDTH(tbq_pkg::SLOT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(tx_slot_valid),
        .in_ready(tx_slot_ready),
        .in_data(tx_slot_data),
        .out_valid(ff_valid),
        .out_ready(ff_pop),
        .out_data(ff_data)
    );

    // receive and transmit state
    tbq_pkg::tbq_align_t state;
    logic [6:0] rx_pos, tx_pos, cur_pos;
    logic [2:0] rx_frame, tx_frame, cur_frame;
    logic [17:0] rx_hist, rx_shift, tx_shift, load_word, hist_next, rx_word;
    logic [22:0] rx_scr, tx_scr, sr1, r1;
    logic [CW-1:0] good, miss;
    logic [1:0] raw, tx_pair;
    logic tx_tick, lock_hit, in_sync, slot_start, ovh_start, do_load, sc1, sc2, sync_sign;
    logic fw_hit, ifw_hit, sync_hit, at_sync, d1, d2, rx_sync_area;

    assign rx_aligned = state == tbq_pkg::ALIGN_LOCKED;
    assign lock_hit = rx_aligned && rx_symbol_valid && rx_pos == PW'(tbq_pkg::TX_OFFSET);
    assign tx_tick = rx_aligned ? rx_symbol_valid : free_tick;
    assign tx_frame_number = tx_frame;
    assign rx_frame_number = rx_frame;

    always_comb begin
        cur_pos = lock_hit ? '0 : tx_pos;
        cur_frame = lock_hit ? rx_frame : tx_frame;
        in_sync = cur_pos < PW'(tbq_pkg::SYNC_SYMS);
        slot_start = in_data_area(cur_pos) && slot_phase(cur_pos) == '0;
        ovh_start = cur_pos == PW'(tbq_pkg::OVH_START);
        do_load = slot_start || ovh_start;
        if (ovh_start) begin
            load_word = {tx_overhead, 12'h000};
        end else begin
            load_word = ff_valid ? ff_data : tbq_pkg::IDLE_SLOT;
        end
        raw = do_load ? load_word[17:16] : tx_shift[17:16];
        sc1 = raw[1] ^ feedback(tx_scr, TX_TAPS);
        sr1 = {tx_scr[21:0], sc1};
        sc2 = raw[0] ^ feedback(sr1, TX_TAPS);
        sync_sign = tbq_pkg::SYNC_SIGNS[4'(8 - cur_pos)] ^ (cur_frame == '0);
        tx_pair = in_sync ? {sync_sign, 1'b0} : {sc1, sc2};
    end

    assign ff_pop = tx_tick && slot_start;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_symbol <= '0;
            tx_symbol_valid <= 1'b0;
        end else begin
            tx_symbol_valid <= tx_tick;
            if (tx_tick) begin
                tx_symbol <= tx_pair;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_pos <= '0;
            tx_frame <= '0;
            tx_shift <= '0;
            tx_scr <= '0;
        end else if (tx_tick) begin
            if (cur_pos == PW'(tbq_pkg::FRAME_SYMS - 1)) begin
                tx_pos <= '0;
                tx_frame <= cur_frame + 1'b1;
            end else begin
                tx_pos <= cur_pos + 1'b1;
                tx_frame <= cur_frame;
            end
            tx_shift <= (do_load ? load_word : tx_shift) << 2;
            if (!in_sync) begin
                tx_scr <= {sr1[21:0], sc2};
            end
        end
    end

    // receive: demap, descramble, sync search

    always_comb begin
        hist_next = {rx_hist[15:0], rx_symbol};
        fw_hit = hist_next == tbq_pkg::SYNC_PAIRS;
        ifw_hit = hist_next == tbq_pkg::INV_SYNC_PAIRS;
        sync_hit = fw_hit || ifw_hit;
        at_sync = rx_pos == PW'(tbq_pkg::SYNC_SYMS - 1);
        rx_sync_area = rx_pos < PW'(tbq_pkg::SYNC_SYMS);
        d1 = rx_symbol[1] ^ feedback(rx_scr, RX_TAPS);
        r1 = {rx_scr[21:0], rx_symbol[1]};
        d2 = rx_symbol[0] ^ feedback(r1, RX_TAPS);
        rx_word = {rx_shift[15:0], d1, d2};
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_hist <= '0;
            rx_scr <= '0;
            rx_shift <= '0;
        end else if (rx_symbol_valid) begin
            rx_hist <= hist_next;
            rx_shift <= rx_word;
            if (state == tbq_pkg::ALIGN_HUNT || !rx_sync_area) begin
                rx_scr <= {r1[21:0], rx_symbol[0]};
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= tbq_pkg::ALIGN_HUNT;
            rx_pos <= '0;
            rx_frame <= '0;
            good <= '0;
            miss <= '0;
        end else if (rx_symbol_valid) begin
            rx_pos <= rx_pos == PW'(tbq_pkg::FRAME_SYMS - 1) ? '0 : rx_pos + 1'b1;
            if (sync_hit && (state == tbq_pkg::ALIGN_HUNT || at_sync)) begin
                rx_frame <= ifw_hit ? '0 : rx_frame + 1'b1;
            end
            case (state)
                tbq_pkg::ALIGN_HUNT: begin
                    if (sync_hit) begin
                        rx_pos <= PW'(tbq_pkg::SYNC_SYMS);
                        good <= CW'(1);
                        state <= ALIGN_COUNT == 1 ? tbq_pkg::ALIGN_LOCKED : tbq_pkg::ALIGN_CHECK;
                        miss <= '0;
                    end
                end
                tbq_pkg::ALIGN_CHECK: begin
                    if (at_sync) begin
                        if (!sync_hit) begin
                            state <= tbq_pkg::ALIGN_HUNT;
                        end else if (good + 1'b1 == CW'(ALIGN_COUNT)) begin
                            state <= tbq_pkg::ALIGN_LOCKED;
                        end else begin
                            good <= good + 1'b1;
                        end
                    end
                end
                tbq_pkg::ALIGN_LOCKED: begin
                    if (at_sync) begin
                        if (sync_hit) begin
                            miss <= '0;
                        end else if (miss + 1'b1 == CW'(LOSS_COUNT)) begin
                            state <= tbq_pkg::ALIGN_HUNT;
                        end else begin
                            miss <= miss + 1'b1;
                        end
                    end
                end
                default: begin
                    state <= tbq_pkg::ALIGN_HUNT;
                end
            endcase
        end
    end

    // demultiplex slots and overhead once aligned
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_slot_data <= '0;
            rx_slot_valid <= 1'b0;
            rx_overhead <= '0;
            rx_overhead_valid <= 1'b0;
        end else begin
            rx_slot_valid <= 1'b0;
            rx_overhead_valid <= 1'b0;
            if (rx_symbol_valid && rx_aligned) begin
                if (in_data_area(rx_pos) && slot_phase(rx_pos) == 4'(tbq_pkg::SLOT_SYMS - 1)) begin
                    rx_slot_data <= rx_word;
                    rx_slot_valid <= 1'b1;
                end
                if (rx_pos == PW'(tbq_pkg::FRAME_SYMS - 1)) begin
                    rx_overhead <= rx_word[5:0];
                    rx_overhead_valid <= 1'b1;
                end
            end
        end
    end

    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_tx_sync_word: assert property (
        tx_tick && in_sync && cur_frame != '0 |=>
        tx_symbol == {tbq_pkg::SYNC_SIGNS[4'(8 - $past(cur_pos))], 1'b0})
        else $error("normal frame sync symbol wrong");
    a_tx_inv_sync: assert property (
        tx_tick && in_sync && cur_frame == '0 |=>
        tx_symbol == {!tbq_pkg::SYNC_SIGNS[4'(8 - $past(cur_pos))], 1'b0})
        else $error("multiframe sync symbol wrong");
    a_tx_symbol_gap: assert property (
        tx_symbol_valid && !rx_aligned && !$past(rx_aligned) |=> (!tx_symbol_valid || rx_aligned) [*8])
        else $error("free symbol strobes too close");
    a_lock_offset: assert property (
        lock_hit |=> tx_symbol_valid && tx_pos == 7'h01 && tx_frame_number == $past(rx_frame))
        else $error("transmit frame not locked at offset");
    a_fifo_pop_slot: assert property (
        ff_pop && ff_valid |=> tx_shift[17:2] == $past(ff_data[15:0]))
        else $error("slot word not loaded on pop");
    a_ovh_load: assert property (
        tx_tick && ovh_start |=> tx_shift[17:14] == $past(tx_overhead[3:0]))
        else $error("overhead bits not loaded");
    a_rx_multiframe: assert property (
        rx_symbol_valid && rx_aligned && at_sync && ifw_hit |=> rx_frame_number == 3'h0)
        else $error("multiframe start not taken");
    a_rx_loss: assert property (
        rx_symbol_valid && rx_aligned && at_sync && !sync_hit && miss + 1'b1 == CW'(LOSS_COUNT)
        |=> !rx_aligned)
        else $error("alignment not dropped after misses");
    a_rx_slot_word: assert property (
        rx_slot_valid |-> $past(rx_symbol_valid) && $past(slot_phase(rx_pos)) == 4'h8)
        else $error("slot delivered at wrong position");
endmodule

// ---- core/tbq_pkg.sv ----
// constants and types of the four-level line framer
package tbq_pkg;
    localparam int CLOCK_HZ = 25000000;
    localparam int BAUD_HZ = 80000;
    localparam int ACC_STEP = BAUD_HZ / 1000;
    localparam int ACC_MOD = CLOCK_HZ / 1000;
    localparam int ACC_W = $clog2(ACC_MOD) + 1;
    localparam int POS_W = 7;
    localparam int FRM_W = 3;
    localparam int CNT_W = 4;
    localparam int SCR_W = 23;
    localparam int SLOT_W = 18;
    localparam int OVH_W = 6;
    localparam int FRAME_SYMS = 120;
    localparam int SYNC_SYMS = 9;
    localparam int SLOT_SYMS = 9;
    localparam int SLOTS = 12;
    localparam int OVH_START = SYNC_SYMS + SLOTS * SLOT_SYMS;
    localparam int FRAMES = 8;
    localparam int TX_OFFSET = 60;
    localparam int ALIGN_DEF = 3;
    localparam int LOSS_DEF = 3;
    localparam logic [8:0] SYNC_SIGNS = 9'h18B;
    localparam logic [17:0] SYNC_PAIRS = 18'h2808A;
    localparam logic [17:0] INV_SYNC_PAIRS = 18'h02A20;
    localparam logic [22:0] SCR_TAPS_DEF = 23'h420000;
    localparam logic [17:0] IDLE_SLOT = 18'h3FFFF;
    typedef enum logic [2:0] {
        ALIGN_HUNT = 3'h1,
        ALIGN_CHECK = 3'h2,
        ALIGN_LOCKED = 3'h4
    } tbq_align_t;
endpackage

// ---- verif/tbq_peer.sv ----
// peer line transceiver model that sends and decodes four-level frames
`timescale 1ns/1ps
module tbq_peer #(
    parameter int PERIOD = 4
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic corrupt,
    output logic [1:0] rx_symbol,
    output logic rx_symbol_valid,
    output logic [6:0] pos,
    output logic [2:0] frame,
    input wire logic [1:0] tx_symbol,
    input wire logic tx_symbol_valid,
    output logic [17:0] got_slot,
    output logic got_valid,
    output logic [5:0] got_ovh
);
    localparam logic [8:0] SYNC = 9'h18B;
    logic [22:0] scr, dscr;
    logic [17:0] w, win, shreg;
    logic [6:0] np, rpos;
    logic [2:0] nf;
    logic [1:0] b, d;
    int cnt;

    function automatic logic [17:0] slot_word(input logic [2:0] f, input int s);
        return {4'hA, f, s[3:0], 7'h35};
    endfunction

    function automatic logic [5:0] ovh_word(input logic [2:0] f);
        return {3'h5, f};
    endfunction

    // sender: bare sync word, all else scrambled, corrupt spoils the sync
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt = 0;
            scr = '0;
            pos <= 7'h77;
            frame <= 3'h7;
            rx_symbol <= 2'h1;
            rx_symbol_valid <= 1'b0;
        end else begin
            rx_symbol_valid <= 1'b0;
            rx_symbol <= ~rx_symbol;
            cnt = enable ? cnt + 1 : 0;
            if (cnt == PERIOD) begin
                cnt = 0;
                np = (pos == 7'd119) ? 7'h0 : pos + 7'h1;
                nf = (np == 7'h0) ? frame + 3'h1 : frame;
                if (np < 7'd9) begin
                    b = {SYNC[8 - np] ^ (nf == 3'h0), corrupt};
                end else begin
                    if (np < 7'd117) begin
                        w = slot_word(nf, (np - 9) / 9) << (2 * ((np - 9) % 9));
                    end else begin
                        w = {ovh_word(nf), 12'h0} << (2 * (np - 117));
                    end
                    b = w[17:16];
                    b[1] = b[1] ^ scr[22] ^ scr[17];
                    scr = {scr[21:0], b[1]};
                    b[0] = b[0] ^ scr[22] ^ scr[17];
                    scr = {scr[21:0], b[0]};
                end
                pos <= np;
                frame <= nf;
                rx_symbol <= b;
                rx_symbol_valid <= 1'b1;
            end
        end
    end

    // decoder of the far transmit stream, restarted at every sync word
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dscr = '0;
            win = '0;
            shreg = '0;
            rpos = 7'd120;
            got_valid <= 1'b0;
            got_slot <= '0;
            got_ovh <= '0;
        end else begin
            got_valid <= 1'b0;
            if (tx_symbol_valid) begin
                win = {win[15:0], tx_symbol};
                if (win == 18'h2808A || win == 18'h02A20) begin
                    rpos = 7'd9;
                end else if (rpos < 7'd120) begin
                    d[1] = tx_symbol[1] ^ dscr[22] ^ dscr[17];
                    dscr = {dscr[21:0], tx_symbol[1]};
                    d[0] = tx_symbol[0] ^ dscr[22] ^ dscr[17];
                    dscr = {dscr[21:0], tx_symbol[0]};
                    shreg = {shreg[15:0], d};
                    if (rpos == 7'd119) got_ovh <= shreg[5:0];
                    if (rpos < 7'd117 && (rpos - 9) % 9 == 8) begin
                        got_slot <= shreg;
                        got_valid <= 1'b1;
                    end
                    rpos = rpos + 7'd1;
                end
            end
        end
    end
endmodule

// ---- verif/tbq_framer_tb.sv ----
// self-checking bench for the four-level line framer
`timescale 1ns/1ps
module tbq_framer_tb;
    localparam logic [8:0] IFW_SIGNS = 9'h074;
    logic clock, reset_n, tx_slot_valid, tx_slot_ready, tx_symbol_valid, rx_symbol_valid;
    logic rx_slot_valid, rx_overhead_valid, rx_aligned, peer_enable, peer_corrupt, got_valid;
    logic [17:0] tx_slot_data, rx_slot_data, got_slot, tx_win;
    logic [5:0] tx_overhead, rx_overhead, got_ovh;
    logic [1:0] tx_symbol, rx_symbol;
    logic [2:0] tx_frame_number, rx_frame_number, peer_frame;
    logic [6:0] peer_pos;
    logic [17:0] words [5] = '{18'h2A5C3, 18'h15A3E, 18'h3C00D, 18'h00F0F, 18'h3FFFF};
    logic [1:0] tx_log [$];
    logic [17:0] got_log [$];
    int gap_log [$];
    int n_errors = 0;
    int check_count = 0;
    int n_ifw = 0;
    int n_fw = 0;
    int cycle = 0;
    int last_tx = 0;
    int aligned_cycles = 0;

    tbq_framer #(.ALIGN_COUNT(3), .LOSS_COUNT(3)) tbq_framer_i (
        .clock(clock), .reset_n(reset_n), .tx_slot_valid(tx_slot_valid), .tx_slot_ready(tx_slot_ready),
        .tx_slot_data(tx_slot_data), .tx_overhead(tx_overhead), .tx_symbol(tx_symbol),
        .tx_symbol_valid(tx_symbol_valid), .tx_frame_number(tx_frame_number), .rx_symbol(rx_symbol),
        .rx_symbol_valid(rx_symbol_valid), .rx_slot_data(rx_slot_data), .rx_slot_valid(rx_slot_valid),
        .rx_overhead(rx_overhead), .rx_overhead_valid(rx_overhead_valid),
        .rx_frame_number(rx_frame_number), .rx_aligned(rx_aligned));

    tbq_peer #(.PERIOD(4)) tbq_peer_i (
        .clock(clock), .reset_n(reset_n), .enable(peer_enable), .corrupt(peer_corrupt),
        .rx_symbol(rx_symbol), .rx_symbol_valid(rx_symbol_valid), .pos(peer_pos), .frame(peer_frame),
        .tx_symbol(tx_symbol), .tx_symbol_valid(tx_symbol_valid), .got_slot(got_slot), .got_valid(got_valid),
        .got_ovh(got_ovh));

    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wait_pos(input int p);
        for (int i = 0; i < 600 && peer_pos != p; i++) step(1);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // log of transmit symbols, lock offset and delivery gating
    always @(posedge clock) begin
        cycle++;
        aligned_cycles = (rx_aligned === 1'b1) ? aligned_cycles + 1 : 0;
        if (got_valid === 1'b1) got_log.push_back(got_slot);
        if (rx_slot_valid === 1'b1) chk("aligned at delivery", 1, rx_aligned);
        if (tx_symbol_valid === 1'b1) begin
            tx_log.push_back(tx_symbol);
            gap_log.push_back(cycle - last_tx);
            last_tx = cycle;
            tx_win = {tx_win[15:0], tx_symbol};
            if (aligned_cycles > 500 && (tx_win === 18'h02A20 || tx_win === 18'h2808A)) begin
                if (tx_win === 18'h02A20) n_ifw++;
                else n_fw++;
                chk("tx sync at peer pos", 68, peer_pos);
                chk("tx sync kind", 18'(tx_win === 18'h02A20), 18'(peer_frame == 3'h0));
                chk("tx frame number", 18'(tx_win === 18'h02A20), 18'(tx_frame_number == 3'h0));
            end
        end
    end

    task automatic t_reset();
        chk("slot ready", 1, tx_slot_ready);
        chk("aligned", 0, rx_aligned);
        chk("output strobes", 0, {tx_symbol_valid, rx_slot_valid, rx_overhead_valid});
        $display("test reset done");
    endtask

    task automatic t_fifo_fill();
        int n;
        n = 0;
        tx_slot_valid = 1'b1;
        for (int i = 0; i < 8; i++) begin
            tx_slot_data = words[n % 4];
            @(posedge clock);
            if (tx_slot_ready === 1'b1) n++;
            #1;
        end
        tx_slot_valid = 1'b0;
        chk("words accepted", 4, 18'(n));
        chk("slot ready full", 0, tx_slot_ready);
        $display("test fifo fill done");
    endtask

    task automatic t_free_ifw();
        for (int i = 0; i < 4000 && tx_log.size() < 9; i++) step(1);
        chk("free symbols", 1, 18'(tx_log.size() >= 9));
        for (int k = 0; k < 9 && k < tx_log.size(); k++) begin
            chk("free sync symbol", {IFW_SIGNS[8 - k], 1'b0}, tx_log[k]);
            if (k > 0) chk("free gap ok", 1, 18'(gap_log[k] == 312 || gap_log[k] == 313));
        end
        $display("test free sync done");
    endtask

    task automatic t_tx_slots();
        for (int i = 0; i < 25000 && got_log.size() < 5; i++) step(1);
        chk("tx slots seen", 1, 18'(got_log.size() >= 5));
        for (int i = 0; i < 5 && i < got_log.size(); i++) chk("tx slot", words[i], got_log[i]);
        chk("slot ready drained", 1, tx_slot_ready);
        $display("test tx slots done");
    endtask

    task automatic t_rx_lock();
        int n;
        n = 0;
        peer_enable = 1'b1;
        for (int i = 0; i < 3000 && rx_aligned !== 1'b1; i++) step(1);
        chk("aligned", 1, rx_aligned);
        for (int i = 0; i < 4000 && n < 26; i++) begin
            if (rx_slot_valid === 1'b1) begin
                n++;
                chk("rx slot", tbq_peer_i.slot_word(peer_frame, (peer_pos - 9) / 9), rx_slot_data);
                chk("rx frame", 18'(peer_frame), 18'(rx_frame_number));
            end
            if (rx_overhead_valid === 1'b1) begin
                n++;
                chk("rx overhead", 18'(tbq_peer_i.ovh_word(peer_frame)), 18'(rx_overhead));
            end
            step(1);
        end
        chk("rx deliveries", 26, 18'(n));
        $display("test rx lock done");
    endtask

    task automatic t_tx_lock();
        for (int i = 0; i < 8000 && (n_ifw < 1 || n_fw < 1); i++) step(1);
        chk("locked sync words", 1, 18'(n_ifw > 0 && n_fw > 0));
        chk("tx overhead", 18'(tx_overhead), 18'(got_ovh));
        $display("test tx lock done");
    endtask

    task automatic t_loss();
        wait_pos(20);
        peer_corrupt = 1'b1;
        for (int k = 1; k <= 3; k++) begin
            wait_pos(10);
            chk("aligned after miss", 18'(k < 3), rx_aligned);
            wait_pos(20);
        end
        peer_corrupt = 1'b0;
        for (int i = 0; i < 3000 && rx_aligned !== 1'b1; i++) step(1);
        chk("realigned", 1, rx_aligned);
        $display("test loss done");
    endtask

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        #2400000;
        n_errors++;
        $display("BAD watchdog expected end seen timeout");
        tally_and_finish();
    end

    initial begin
        reset_n = 1'b0;
        tx_slot_valid = 1'b0;
        tx_slot_data = '0;
        tx_overhead = 6'h2D;
        peer_enable = 1'b0;
        peer_corrupt = 1'b0;
        tx_win = '0;
        step(3);
        t_reset();
        reset_n = 1'b1;
        t_fifo_fill();
        t_free_ifw();
        t_tx_slots();
        t_rx_lock();
        t_tx_lock();
        t_loss();
        tally_and_finish();
    end
endmodule
